// File: hw/prsl_regs.svh
// Constants for the power-up reset and security lock block.
`ifndef PRSL_REGS_SVH
`define PRSL_REGS_SVH
`define PRSL_CLK_HZ          40000000
`define PRSL_RESET_DELAY_NS  1000
// Reset hold count: 1000 ns at 25 ns per cycle, rounded down for a longest time.
`define PRSL_RESET_CYCLES    ((`PRSL_RESET_DELAY_NS * (`PRSL_CLK_HZ / 1000000)) / 1000)
`define PRSL_NUM_CELLS       10
`define PRSL_CFG_BITS        16
`define PRSL_SIG_BITS        32
`define PRSL_SIG_RESET       32'h0000_0000
// Scan instruction codes, 4 bits wide.
`define PRSL_IR_BYPASS       4'hF
`define PRSL_IR_USERCODE     4'h8
`define PRSL_IR_READ         4'h1
`define PRSL_IR_PROG         4'h2
`define PRSL_IR_VERIFY       4'h3
`define PRSL_IR_ERASE        4'h4
`define PRSL_IR_LOCK         4'h5
`define PRSL_IR_SIGWR        4'h6
`endif

// File: hw/prsl_pkg.sv
// Types for the power-up reset and security lock block.
package prsl_pkg;
	typedef enum logic [3:0] {
		TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
		TAP_SH_DR  = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR  = 4'h6, TAP_EX2_DR = 4'h7,
		TAP_UP_DR  = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR  = 4'hB,
		TAP_EX1_IR = 4'hC, TAP_PA_IR  = 4'hD, TAP_EX2_IR = 4'hE, TAP_UP_IR  = 4'hF
	} prsl_tap_t;
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} prsl_scan_in_t;
endpackage : prsl_pkg

// File: hw/prsl_sync.sv
// Three-stage input synchroniser with agreement filter.
module prsl_sync (
	input  wire logic core_clk, // System clock.
	input  wire logic reset,    // Synchronous reset.
	input  wire logic din,      // Asynchronous input.
	output logic      dout      // Filtered level.
);
	logic s1;
	logic s2;
	logic s3;

	// Shift chain; the first stage feeds only the second.
	always_ff @(posedge core_clk) begin
		s1 <= din;
		s2 <= s1;
		s3 <= s2;
	end

	// A change counts once the second and third stages agree.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			dout <= 1'b0;
		end else if (s2 == s3) begin
			dout <= s3;
		end
	end
endmodule : prsl_sync

// File: hw/prsl_top.sv
// Power-up reset, registered outputs, scan port and security lock.
`include "prsl_regs.svh"
module prsl_top
	import prsl_pkg::*;
(
	input  wire logic                           core_clk,  // System clock, 40 MHz.
	input  wire logic                           reset,     // Synchronous reset.
	input  wire logic                           power_good, // Supply good, asynchronous.
	input  wire logic [`PRSL_NUM_CELLS-1:0]     cell_d,    // Macrocell D inputs.
	input  wire logic [`PRSL_NUM_CELLS-1:0]     cell_oe,   // Macrocell output enables.
	input  wire prsl_scan_in_t                  scan_in,   // Scan clock, mode, data.
	output logic [`PRSL_NUM_CELLS-1:0]          pin_out,   // Output pin levels.
	output logic [`PRSL_NUM_CELLS-1:0]          pin_oe,    // Output pin enables.
	output logic                                tdo,       // Scan data out.
	output logic                                tdo_oe,    // Scan data out enable.
	output logic                                por_active, // Internal reset active.
	output logic                                locked     // Security lock state.
);
	localparam int RST_CYC = (`PRSL_RESET_CYCLES < 1) ? 1 : `PRSL_RESET_CYCLES;
	localparam int DRW     = `PRSL_SIG_BITS;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic pg_s;
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	prsl_sync u_pg  (.core_clk(core_clk), .reset(1'b0),  .din(power_good),  .dout(pg_s));
	prsl_sync u_tck (.core_clk(core_clk), .reset(reset), .din(scan_in.tck), .dout(tck_s));
	prsl_sync u_tms (.core_clk(core_clk), .reset(reset), .din(scan_in.tms), .dout(tms_s));
	prsl_sync u_tdi (.core_clk(core_clk), .reset(reset), .din(scan_in.tdi), .dout(tdi_s));

	// ------------------------------------------------------------
	// Power-up reset
	// ------------------------------------------------------------
	logic [5:0] por_cnt;
	logic       por;

	// Hold reset for a fixed count after power-good rises.
	always_ff @(posedge core_clk) begin
		if (reset || !pg_s) begin
			por_cnt <= 6'h00;
			por     <= 1'b1;
		end else if (por_cnt < 6'(RST_CYC - 1)) begin
			por_cnt <= por_cnt + 6'h01;
			por     <= 1'b1;
		end else begin
			por     <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		por_active <= por;
	end

	// ------------------------------------------------------------
	// Macrocell registers and output polarity
	// ------------------------------------------------------------
	logic [`PRSL_NUM_CELLS-1:0] cell_q;
	logic [`PRSL_CFG_BITS-1:0]  cfg;

	// Register reset ignores polarity entirely.
	always_ff @(posedge core_clk) begin
		if (por) begin
			cell_q <= '0;
		end else begin
			cell_q <= cell_d;
		end
	end

	// Polarity is applied after the register, from the low config bits.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pin_out <= '0;
			pin_oe  <= '0;
		end else begin
			pin_out <= cell_q ^ cfg[`PRSL_NUM_CELLS-1:0];
			pin_oe  <= cell_oe & ~{`PRSL_NUM_CELLS{por}};
		end
	end

	// ------------------------------------------------------------
	// Scan port state machine
	// ------------------------------------------------------------
	prsl_tap_t  tap;
	prsl_tap_t  next_tap;
	logic       tck_d;
	logic       rise;
	logic       fall;
	assign rise = tck_s & ~tck_d;
	assign fall = ~tck_s & tck_d;

	always_ff @(posedge core_clk) begin
		tck_d <= reset ? 1'b0 : tck_s;
	end

	// Standard sixteen-state controller.
	always_comb begin
		next_tap = tap;
		unique case (tap)
			TAP_RESET:  next_tap = tms_s ? TAP_RESET  : TAP_IDLE;
			TAP_IDLE:   next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: next_tap = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: next_tap = tms_s ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR:  next_tap = tms_s ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: next_tap = tms_s ? TAP_UP_DR  : TAP_PA_DR;
			TAP_PA_DR:  next_tap = tms_s ? TAP_EX2_DR : TAP_PA_DR;
			TAP_EX2_DR: next_tap = tms_s ? TAP_UP_DR  : TAP_SH_DR;
			TAP_UP_DR:  next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: next_tap = tms_s ? TAP_RESET  : TAP_CAP_IR;
			TAP_CAP_IR: next_tap = tms_s ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR:  next_tap = tms_s ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: next_tap = tms_s ? TAP_UP_IR  : TAP_PA_IR;
			TAP_PA_IR:  next_tap = tms_s ? TAP_EX2_IR : TAP_PA_IR;
			TAP_EX2_IR: next_tap = tms_s ? TAP_UP_IR  : TAP_SH_IR;
			TAP_UP_IR:  next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			tap <= TAP_RESET;
		end else if (rise) begin
			tap <= next_tap;
		end
	end

	// ------------------------------------------------------------
	// Instruction and data shift registers
	// ------------------------------------------------------------
	logic [3:0]     ir_sh;
	logic [3:0]     ir;
	logic [DRW-1:0] dr;
	logic [DRW-1:0] sig;

	// Instruction path; test-logic reset selects bypass.
	always_ff @(posedge core_clk) begin
		if (reset || tap == TAP_RESET) begin
			ir_sh <= 4'h1;
			ir    <= `PRSL_IR_BYPASS;
		end else if (rise) begin
			if (tap == TAP_CAP_IR) ir_sh <= 4'h1;
			if (tap == TAP_SH_IR)  ir_sh <= {tdi_s, ir_sh[3:1]};
			if (tap == TAP_UP_IR)  ir    <= ir_sh;
		end
	end

	// Data path capture; configuration readback yields zero while locked.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			dr <= '0;
		end else if (rise && tap == TAP_CAP_DR) begin
			unique case (ir)
				`PRSL_IR_USERCODE: dr <= sig;
				`PRSL_IR_READ:     dr <= locked ? '0 : {16'h0000, cfg};
				`PRSL_IR_VERIFY:   dr <= locked ? '0 : {16'h0000, cfg};
				default:           dr <= '0;
			endcase
		end else if (rise && tap == TAP_SH_DR) begin
			dr <= (ir == `PRSL_IR_BYPASS) ? {{(DRW-1){1'b0}}, tdi_s}
			                              : {tdi_s, dr[DRW-1:1]};
		end
	end

	// ------------------------------------------------------------
	// Configuration, signature and lock update
	// ------------------------------------------------------------
	logic upd;
	assign upd = rise && tap == TAP_UP_DR;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cfg    <= '0;
			sig    <= `PRSL_SIG_RESET;
			locked <= 1'b0;
		end else if (upd) begin
			unique case (ir)
				`PRSL_IR_ERASE: begin
					cfg    <= '0;
					sig    <= `PRSL_SIG_RESET;
					locked <= 1'b0;
				end
				`PRSL_IR_PROG:  if (!locked) cfg <= dr[`PRSL_CFG_BITS-1:0];
				`PRSL_IR_SIGWR: if (!locked) sig <= dr;
				`PRSL_IR_LOCK:  locked <= 1'b1;
				default: ;
			endcase
		end
	end

	// Output data changes on the falling scan clock.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (fall) begin
			tdo    <= (tap == TAP_SH_IR) ? ir_sh[0] : dr[0];
			tdo_oe <= (tap == TAP_SH_IR) || (tap == TAP_SH_DR);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [6:0] pg_age;
	logic [2:0] tms_ones;

	// Counts cycles since power-good was seen high, so the reset length is checked.
	always_ff @(posedge core_clk) begin
		if (reset || !pg_s) begin
			pg_age <= 7'h00;
		end else if (pg_age != 7'h7F) begin
			pg_age <= pg_age + 7'h01;
		end
	end

	// Counts consecutive scan clock rises with the mode input high.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tms_ones <= 3'h0;
		end else if (rise) begin
			tms_ones <= !tms_s ? 3'h0 : (tms_ones == 3'h7) ? 3'h7 : tms_ones + 3'h1;
		end
	end

	sequence s_por_drop;
		por ##1 !por;
	endsequence

	AST_POR_ZERO: assert property (@(posedge core_clk)
		por |=> cell_q == '0) else $error("Cell not cleared in reset.");
	AST_POR_LEN: assert property (@(posedge core_clk) disable iff (reset)
		s_por_drop |-> pg_age == 7'(RST_CYC)) else $error("Reset length wrong.");
	AST_POR_END: assert property (@(posedge core_clk) disable iff (reset)
		pg_age == 7'(RST_CYC) |-> !por) else $error("Reset not released.");
	AST_PIN_POL: assert property (@(posedge core_clk) disable iff (reset)
		$past(por) && por |=> pin_out == $past(cfg[`PRSL_NUM_CELLS-1:0]))
		else $error("Pin polarity.");
	AST_READ_LOCK: assert property (@(posedge core_clk) disable iff (reset)
		rise && tap == TAP_CAP_DR && ir == `PRSL_IR_READ && locked |=> dr == '0)
		else $error("Readback leaked.");
	AST_PROG_LOCK: assert property (@(posedge core_clk) disable iff (reset)
		upd && ir == `PRSL_IR_PROG && locked |=> $stable(cfg)) else $error("Program passed.");
	AST_LOCK_HOLD: assert property (@(posedge core_clk) disable iff (reset)
		locked && !(upd && ir == `PRSL_IR_ERASE) |=> locked) else $error("Lock dropped.");
	AST_SIG_READ: assert property (@(posedge core_clk) disable iff (reset)
		rise && tap == TAP_CAP_DR && ir == `PRSL_IR_USERCODE |=> dr == $past(sig))
		else $error("Signature unreadable.");
	AST_TAP_RST: assert property (@(posedge core_clk) disable iff (reset)
		rise && tms_s && tms_ones >= 3'h4 |=> tap == TAP_RESET)
		else $error("Five TMS highs no reset.");
endmodule : prsl_top

// File: test/prsl_scan_host.sv
// Scan programmer model that drives the test access port.
module prsl_scan_host
	import prsl_pkg::*;
(
	input  wire logic core_clk, // System clock.
	input  wire logic tdo,      // Scan data from the device.
	input  wire logic tdo_oe,   // Scan data drive enable from the device.
	output prsl_scan_in_t scan_in // Scan clock, mode and data.
);
	timeunit 1ns;
	timeprecision 1ps;
	// The scan clock stands low outside frames.
	initial scan_in = '0;
	// One scan clock period of sixteen system clocks, tdo taken before the rise.
	task automatic step(input logic ms, input logic di, output logic so);
		scan_in.tms = ms;
		scan_in.tdi = di;
		repeat (8) @(negedge core_clk);
		// A released data line floats to the board pull-up level.
		so = tdo_oe ? tdo : 1'b1;
		scan_in.tck = 1'b1;
		repeat (8) @(negedge core_clk);
		scan_in.tck = 1'b0;
	endtask : step
	// Five mode highs reach the reset state, one low parks in idle.
	task automatic tap_reset;
		logic so;
		repeat (5) step(1'b1, 1'b0, so);
		step(1'b0, 1'b0, so);
	endtask : tap_reset
	// One instruction or data scan from idle back to idle, least bit first.
	task automatic scan(input logic ir, input logic [31:0] din, input int n,
		output logic [31:0] dout);
		logic so;
		dout = '0;
		step(1'b1, 1'b0, so);
		if (ir) step(1'b1, 1'b0, so);
		step(1'b0, 1'b0, so);
		step(1'b0, 1'b0, so);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], so);
			dout[i] = so;
		end
		step(1'b1, 1'b0, so);
		step(1'b0, 1'b0, so);
	endtask : scan
	// An instruction followed by a full data scan.
	task automatic op(input logic [3:0] code, input logic [31:0] din, output logic [31:0] dout);
		logic [31:0] junk;
		scan(1'b1, {28'h0000000, code}, 4, junk);
		scan(1'b0, din, 32, dout);
	endtask : op
endmodule : prsl_scan_host

// File: test/prsl_top_bench.sv
// Testbench for the power-up reset and security lock block.
`include "prsl_regs.svh"
module prsl_top_bench
	import prsl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                       core_clk = 1'b0;
	logic                       reset = 1'b1;
	logic                       power_good = 1'b0;
	logic [`PRSL_NUM_CELLS-1:0] cell_d = '0, cell_oe = '0, pin_out, pin_oe;
	logic                       tdo, tdo_oe, por_active, locked;
	prsl_scan_in_t              scan_in;
	logic [31:0]                rd;
	int                         n_errors = 0, n_checks = 0;
	// Clock of 25 ns.
	always #12.5 core_clk = ~core_clk;
	prsl_top dut (.core_clk(core_clk), .reset(reset), .power_good(power_good),
		.cell_d(cell_d), .cell_oe(cell_oe), .scan_in(scan_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .tdo(tdo), .tdo_oe(tdo_oe), .por_active(por_active), .locked(locked));
	prsl_scan_host host (.core_clk(core_clk), .tdo(tdo), .tdo_oe(tdo_oe), .scan_in(scan_in));
	// -------------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic conclude;
		$display("Checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task automatic run(input logic [3:0] code, input logic [31:0] din);
		host.op(code, din, rd);
	endtask : run
	// Supply drop and rise; pins must show the zeroed cells through polarity pol.
	task automatic power_up(input logic [9:0] pol);
		int n;
		power_good = 1'b0;
		cell_d = 10'h3FF;
		// Wait out the input synchroniser and the register stages behind the reset.
		repeat (8) @(negedge core_clk);
		check(32'(por_active), 32'h1);
		power_good = 1'b1;
		n = 0;
		while (por_active === 1'b1 && n < 100) begin
			check(32'(pin_out), 32'(pol));
			check(32'(pin_oe), 32'h0);
			@(negedge core_clk);
			n++;
		end
		check(32'(n >= 40 && n <= 48), 32'h1);
		if (n == 100) conclude();
		// Inputs stay steady well past release before they are relied on.
		repeat (4) @(negedge core_clk);
		check(32'(pin_out), 32'(10'h3FF ^ pol));
		check(32'(pin_oe), 32'(cell_oe));
		cell_d = 10'h000;
		repeat (4) @(negedge core_clk);
		check(32'(pin_out), 32'(pol));
	endtask : power_up
	// -------------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------------
	initial begin
		repeat (3) @(negedge core_clk);
		reset = 1'b0;
		cell_oe = 10'h3FF;
		power_up(10'h000);
		host.tap_reset();
		host.scan(1'b0, 32'hC3A5_9617, 32, rd);
		check(rd, 32'h874B_2C2E);
		run(`PRSL_IR_SIGWR, 32'h5A3C_96E1);
		run(`PRSL_IR_USERCODE, 32'h0);
		check(rd, 32'h5A3C_96E1);
		run(`PRSL_IR_PROG, 32'h0000_0205);
		run(`PRSL_IR_READ, 32'h0);
		check(32'(rd[15:0]), 32'h0205);
		run(`PRSL_IR_VERIFY, 32'h0);
		check(32'(rd[15:0]), 32'h0205);
		power_up(10'h205);
		run(`PRSL_IR_LOCK, 32'h0);
		check(32'(locked), 32'h1);
		run(`PRSL_IR_READ, 32'h0);
		check(32'(rd[15:0]), 32'h0000);
		run(`PRSL_IR_PROG, 32'h0000_0001);
		run(`PRSL_IR_VERIFY, 32'h0);
		check(32'(rd[15:0]), 32'h0000);
		run(`PRSL_IR_SIGWR, 32'h1111_1111);
		run(`PRSL_IR_USERCODE, 32'h0);
		check(rd, 32'h5A3C_96E1);
		power_up(10'h205);
		host.tap_reset();
		check(32'(locked), 32'h1);
		run(`PRSL_IR_ERASE, 32'h0);
		check(32'(locked), 32'h0);
		run(`PRSL_IR_USERCODE, 32'h0);
		check(rd, `PRSL_SIG_RESET);
		run(`PRSL_IR_READ, 32'h0);
		check(32'(rd[15:0]), 32'h0000);
		power_up(10'h000);
		conclude();
	end
endmodule : prsl_top_bench
